// *** pkg/acs_pkg.sv ***
// package of constants and types for the conversion sequencer
//------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------
// Summary of operation
// - any reference register write starts a conversion
// - write during conversion aborts and restarts it
// - conversion and busy begin next cycle
// - two nibbles pick lower and upper reference
// - phases run load, sample, then convert
// - load and sample phases connect array to selected channel
// - result written last cycle, busy cleared before
// - done flag set cycles before result
// - busy clears one cycle before result becomes readable
// - continuous mode restarts right after last cycle
// - conversion lasts 13 or 15 cycles
// - single stops once, continuous repeats until cleared
// - three-bit field selects one of eight inputs
// - busy bit four is read-only
package acs_pkg;

   //---------------------------------------------------------------
   // register byte addresses
   //---------------------------------------------------------------
   localparam logic [7:0] ACS_CTRL_IDX   = 8'hd8;
   localparam logic [7:0] ACS_RESULT_IDX = 8'hd9;
   localparam logic [7:0] ACS_REFPRG_IDX = 8'hda;
   localparam logic [11:0] ACS_CTRL_ADDR   = 12'h360;
   localparam logic [11:0] ACS_RESULT_ADDR = 12'h364;
   localparam logic [11:0] ACS_REFPRG_ADDR = 12'h368;
   localparam logic [11:0] ACS_IRQ_ADDR    = 12'h370;
   localparam logic [11:0] ACS_MASK_ADDR   = 12'h374;

   //---------------------------------------------------------------
   // field positions and reset values
   //---------------------------------------------------------------
   localparam int ACS_BUSY_BIT = 4;
   localparam int ACS_CONT_BIT = 3;
   localparam int ACS_DONE_BIT = 0;
   localparam logic [7:0] ACS_CTRL_RST   = 8'h00;
   localparam logic [7:0] ACS_REFPRG_RST = 8'h00;
   localparam logic [7:0] ACS_RESULT_RST = 8'h00;
   localparam logic [7:0] ACS_MASK_RST   = 8'h00;

   //---------------------------------------------------------------
   // timing counts in machine cycles
   //---------------------------------------------------------------
   localparam logic [3:0] ACS_CYC_NEW  = 4'hd;
   localparam logic [3:0] ACS_CYC_OLD  = 4'hf;
   localparam logic [3:0] ACS_LOAD_END = 4'h2;
   localparam logic [3:0] ACS_SAMP_END = 4'h4;
   localparam logic [3:0] ACS_IRQ_LEAD = 4'h3;
   localparam logic [3:0] ACS_BSY_LEAD = 4'h1;

   typedef enum logic [1:0] {ACS_IDLE, ACS_LOAD, ACS_SAMPLE, ACS_CONVERT} acs_phase_t;

   typedef struct packed {
      logic [7:0] lower_code;
      logic [7:0] upper_code;
   } acs_refs_t;

   typedef struct packed {
      logic       start;
      logic       abort;
      logic [2:0] channel;
   } acs_cmd_t;

endpackage : acs_pkg

// *** rtl/acs_reference_decode.sv ***
// maps the reference program register onto two ladder tap selects
`timescale 1ns/1ps
module acs_reference_decode
(
   // program value
   input  wire logic [7:0]       reference_program_reg,
   // ladder taps
   output acs_pkg::acs_refs_t    refs
);
   import acs_pkg::*;

   // code 0 on the upper nibble means the full external span (tap 16)
   always_comb
   begin
      refs.lower_code = {4'h0, reference_program_reg[3:0]};
      refs.upper_code = (reference_program_reg[7:4] == 4'h0) ? 8'h10
                        : {4'h0, reference_program_reg[7:4]};
   end
endmodule : acs_reference_decode

// *** rtl/acs_sequencer.sv ***
// phase sequencer: counts machine cycles of one conversion
`timescale 1ns/1ps
module acs_sequencer
(
   // clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             ce,
   // control
   input  wire acs_pkg::acs_cmd_t cmd,
   input  wire logic             continuous,
   input  wire logic             older_variant,
   // status
   output acs_pkg::acs_phase_t   phase,
   output logic                  busy,
   output logic                  irq_pulse,
   output logic                  result_pulse
);
   import acs_pkg::*;

   typedef struct packed {
      acs_phase_t phase;
      logic [3:0] cnt;
      logic       busy;
   } acs_seq_state_t;

   acs_seq_state_t st;
   acs_seq_state_t next_st;
   logic [3:0]     total;

   assign total = older_variant ? ACS_CYC_OLD : ACS_CYC_NEW;

   // restart on any start; cnt counts 1..total
   always_comb
   begin
      next_st      = st;
      irq_pulse    = 1'b0;
      result_pulse = 1'b0;
      if (cmd.start)
      begin
         next_st.phase = ACS_LOAD;
         next_st.cnt   = 4'h1;
         next_st.busy  = 1'b1;
      end
      else if (st.phase != ACS_IDLE)
      begin
         irq_pulse    = (st.cnt == total - ACS_IRQ_LEAD);
         result_pulse = (st.cnt == total);
         if (st.cnt == total - ACS_BSY_LEAD)
            next_st.busy = 1'b0;
         if (st.cnt == total)
         begin
            if (continuous)
            begin
               next_st.phase = ACS_LOAD;
               next_st.cnt   = 4'h1;
               next_st.busy  = 1'b1;
            end
            else
               next_st.phase = ACS_IDLE;
         end
         else
         begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == ACS_LOAD_END)
               next_st.phase = ACS_SAMPLE;
            else if (st.cnt == ACS_SAMP_END)
               next_st.phase = ACS_CONVERT;
         end
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st <= '{ACS_IDLE, 4'h0, 1'b0};
      else if (ce)
         st <= next_st;
   end

   assign phase = st.phase;
   assign busy  = st.busy;

   a_start_busy: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && cmd.start) |=> busy && phase == ACS_LOAD) else $error("no busy after start");
   a_busy_before_res: assert property (@(posedge hclk) disable iff (!hresetn)
      result_pulse |-> !busy) else $error("busy at result");

   // done flag must lead the result write by at least two cycles
   sequence s_flag_lead;
      irq_pulse ##1 !result_pulse;
   endsequence
   a_flag_lead: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && irq_pulse && !cmd.start) |-> s_flag_lead) else $error("flag not ahead");
   a_idle_not_busy: assert property (@(posedge hclk) disable iff (!hresetn)
      phase == ACS_IDLE |-> !busy) else $error("busy while idle");
endmodule : acs_sequencer

// *** rtl/acs_top.sv ***
// converter control: ahb-lite registers, sequencer and interrupt
`timescale 1ns/1ps
module acs_top
(
   // ahb-lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // analog side
   input  wire logic        older_variant,
   input  wire logic [7:0]  comparator_result,
   output logic [7:0]       channel_onehot,
   output logic             sample_connect,
   output acs_pkg::acs_refs_t refs,
   // interrupt
   output logic             irq
);
   import acs_pkg::*;

   typedef struct packed {
      logic        wr_pend;
      logic        rd_pend;
      logic [11:0] addr;
      logic [7:0]  ctrl;
      logic [7:0]  refprg;
      logic [7:0]  result;
      logic        done;
      logic        mask;
      logic [31:0] rdata;
   } acs_top_state_t;

   acs_top_state_t st;
   acs_top_state_t next_st;
   acs_cmd_t       cmd;
   acs_phase_t     phase;
   logic           busy;
   logic           irq_pulse;
   logic           result_pulse;
   logic           ref_wr;

   assign ref_wr = st.wr_pend && st.addr == ACS_REFPRG_ADDR;
   assign cmd.start   = ref_wr;
   assign cmd.abort   = ref_wr && phase != ACS_IDLE;
   assign cmd.channel = st.ctrl[2:0];

   // registers and bus
   always_comb
   begin
      next_st = st;
      next_st.wr_pend = 1'b0;
      next_st.rd_pend = 1'b0;
      if (hsel && hready && htrans[1])
      begin
         next_st.wr_pend = hwrite;
         next_st.rd_pend = !hwrite;
         next_st.addr    = {haddr[11:2], 2'b00};
      end
      if (st.wr_pend)
      begin
         if (st.addr == ACS_CTRL_ADDR)
            next_st.ctrl = hwdata[7:0] & ~(8'h01 << ACS_BUSY_BIT);
         else if (st.addr == ACS_RESULT_ADDR)
            next_st.result = hwdata[7:0];
         else if (st.addr == ACS_REFPRG_ADDR)
            next_st.refprg = hwdata[7:0];
         else if (st.addr == ACS_MASK_ADDR)
            next_st.mask = hwdata[ACS_DONE_BIT];
      end
      if (st.rd_pend && st.addr == ACS_IRQ_ADDR)
         next_st.done = 1'b0;
      if (irq_pulse && !ref_wr)
         next_st.done = 1'b1;
      if (result_pulse && !ref_wr)
         next_st.result = comparator_result;
      next_st.rdata = 32'h0000_0000;
      if (hsel && hready && htrans[1] && !hwrite)
      begin
         if ({haddr[11:2], 2'b00} == ACS_CTRL_ADDR)
            next_st.rdata = {24'h0, next_st.ctrl[7:5], next_st.ctrl[4] | busy,
                             next_st.ctrl[3:0]};
         else if ({haddr[11:2], 2'b00} == ACS_RESULT_ADDR)
            next_st.rdata = {24'h0, next_st.result};
         else if ({haddr[11:2], 2'b00} == ACS_REFPRG_ADDR)
            next_st.rdata = {24'h0, next_st.refprg};
         else if ({haddr[11:2], 2'b00} == ACS_IRQ_ADDR)
            next_st.rdata = {31'h0, next_st.done};
         else if ({haddr[11:2], 2'b00} == ACS_MASK_ADDR)
            next_st.rdata = {31'h0, next_st.mask};
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st <= '{1'b0, 1'b0, 12'h000, ACS_CTRL_RST, ACS_REFPRG_RST, ACS_RESULT_RST,
                 1'b0, 1'b0, 32'h0000_0000};
      else if (ce)
         st <= next_st;
   end

   assign hrdata    = st.rdata;
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign irq       = st.done & st.mask;
   assign sample_connect = phase == ACS_LOAD || phase == ACS_SAMPLE;
   assign channel_onehot = sample_connect ? (8'h01 << st.ctrl[2:0]) : 8'h00;

   acs_sequencer u_seq
   (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .ce           (ce),
      .cmd          (cmd),
      .continuous   (st.ctrl[ACS_CONT_BIT]),
      .older_variant(older_variant),
      .phase        (phase),
      .busy         (busy),
      .irq_pulse    (irq_pulse),
      .result_pulse (result_pulse)
   );

   acs_reference_decode u_ref
   (
      .reference_program_reg (st.refprg),
      .refs                  (refs)
   );

   a_abort_no_result: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && result_pulse && ref_wr) |=> st.result == $past(st.result)) else $error("abort wrote");
   a_channel_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
      sample_connect |-> $onehot(channel_onehot)) else $error("channel not one-hot");
endmodule : acs_top

// *** tb/adc_conversion_sequencer_tb.sv ***
// self-checking bench of the conversion sequencer against fixed expected values
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
   import acs_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        older_variant, sample_connect, irq;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd, v;
   logic [7:0]  comparator_result, channel_onehot, rp;
   acs_refs_t   refs;
   int          bad_count, n_tests, c, c2, i;
   int          dly[2];
   assign hready = hreadyout;
   acs_top uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .older_variant(older_variant),
      .comparator_result(comparator_result), .channel_onehot(channel_onehot),
      .sample_connect(sample_connect), .refs(refs), .irq(irq));
   //---------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // bounded wait; a hang ends the run through the verdict
   task automatic await(ref logic s, input logic lv, output int n);
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (s !== lv && n < 400);
      if (s !== lv)
      begin
         bad_count++;
         print_verdict();
      end
   endtask : await
   // one single ahb-lite transfer, read data left in rd
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      await(hready, 1'b1, n);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      await(hready, 1'b1, n);
      rd = hrdata;
   endtask : bus
   //---------------------------------------------------------------
   // clock and main sequence
   //---------------------------------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial
   begin
      {hresetn, hsel, hwrite, haddr, htrans, hwdata, older_variant} = '0;
      hsize = 3'b010;
      comparator_result = 8'h00;
      v = 32'd79695;
      bad_count = 0;
      n_tests = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, ACS_CTRL_ADDR, 0);
      chk(rd, {24'h0, ACS_CTRL_RST});
      bus(1'b0, ACS_REFPRG_ADDR, 0);
      chk(rd, {24'h0, ACS_REFPRG_RST});
      bus(1'b0, 12'h3fc, 0);
      chk(rd, 0);
      bus(1'b1, ACS_CTRL_ADDR, 32'h17);
      bus(1'b0, ACS_CTRL_ADDR, 0);
      chk(rd, 32'h07);
      $display("registers done");
      bus(1'b1, ACS_MASK_ADDR, 32'h1);
      // every channel, both variants, random codes and results
      for (i = 0; i < 8; i++)
      begin
         older_variant <= i[0];
         v = lfsr(v);
         comparator_result <= v[15:8];
         bus(1'b1, ACS_CTRL_ADDR, i);
         // keep both codes inside their usable ranges
         rp = {(v[7:4] < 4'h4) ? v[7:4] + 4'h4 : v[7:4],
               (v[3:0] > 4'hc) ? v[3:0] - 4'h4 : v[3:0]};
         bus(1'b1, ACS_REFPRG_ADDR, {24'h0, rp});
         bus(1'b0, ACS_CTRL_ADDR, 0);
         chk(rd[4], 1);
         chk(refs.lower_code, {4'h0, rp[3:0]});
         chk(refs.upper_code, (rp[7:4] == 0) ? 16 : rp[7:4]);
         await(sample_connect, 1'b1, c);
         chk(channel_onehot, 8'h01 << i);
         await(irq, 1'b1, c);
         if (i < 2)
            dly[i] = c;
         chk(c, dly[i % 2]);
         c2 = 0;
         do
         begin
            bus(1'b0, ACS_CTRL_ADDR, 0);
            c2++;
         end
         while (rd[4] === 1'b1 && c2 < 100);
         chk(rd[4], 0);
         bus(1'b0, ACS_RESULT_ADDR, 0);
         chk(rd, v[15:8]);
         bus(1'b0, ACS_IRQ_ADDR, 0);
         chk(rd, 1);
         bus(1'b0, ACS_IRQ_ADDR, 0);
         chk({irq, rd[0]}, 0);
      end
      chk(dly[1] - dly[0], 2);
      $display("conversions done");
      // masked flag raises no interrupt until unmasked
      older_variant <= 1'b0;
      bus(1'b1, ACS_MASK_ADDR, 0);
      bus(1'b1, ACS_REFPRG_ADDR, 32'h4c);
      repeat (30) @(posedge hclk);
      chk(irq, 0);
      bus(1'b1, ACS_MASK_ADDR, 32'h1);
      @(posedge hclk);
      chk(irq, 1);
      bus(1'b0, ACS_IRQ_ADDR, 0);
      @(posedge hclk);
      chk(irq, 0);
      $display("mask done");
      // restart in mid-conversion: only the second one completes
      comparator_result <= 8'h5a;
      bus(1'b1, ACS_REFPRG_ADDR, 32'h80);
      repeat (4) @(posedge hclk);
      bus(1'b1, ACS_REFPRG_ADDR, 32'h81);
      bus(1'b0, ACS_CTRL_ADDR, 0);
      await(irq, 1'b1, c);
      chk(c, dly[0] + 1);
      bus(1'b0, ACS_IRQ_ADDR, 0);
      $display("abort done");
      // continuous mode: back-to-back conversions, stop on clear
      bus(1'b1, ACS_CTRL_ADDR, 32'h08);
      bus(1'b1, ACS_REFPRG_ADDR, 32'hf0);
      await(sample_connect, 1'b1, c);
      await(sample_connect, 1'b0, c);
      await(sample_connect, 1'b1, c2);
      chk(c + c2, ACS_CYC_NEW);
      bus(1'b1, ACS_CTRL_ADDR, 0);
      repeat (20) @(posedge hclk);
      c = 0;
      repeat (40)
      begin
         @(posedge hclk);
         c += sample_connect;
      end
      chk(c, 0);
      $display("continuous done");
      print_verdict();
   end
endmodule : adc_conversion_sequencer_tb
